/* hdl/hub_sf_router.sv */
// hub store-and-forward header router with per-port buffer regions
`timescale 1ns/10ps
`include "hub_sf_regs.svh"
module hub_sf_router #(
   parameter int DW = 32,                  // header word width
   parameter int NP = 4,                   // downstream ports, power of two
   parameter int QD = `HUB_REGION_DEPTH    // words per port region
) (
   // clocks and reset
   input  wire logic             I_MCLK,
   input  wire logic             I_RESET_N,
   input  wire logic             I_LCLK,
   // upstream receive, link clock
   input  wire logic             I_US_RX_VALID,
   input  wire logic [DW-1:0]    I_US_RX_DATA,
   output logic                  O_US_RX_READY,
   // upstream transmit
   output logic                  O_US_TX_VALID,
   output logic [DW-1:0]         O_US_TX_DATA,
   output logic                  O_US_TX_SKIP,
   input  wire logic             I_US_TX_READY,
   // downstream receive
   input  wire logic [NP-1:0]    I_DS_RX_VALID,
   input  wire logic [NP*DW-1:0] I_DS_RX_DATA,
   output logic [NP-1:0]         O_DS_RX_READY,
   // downstream transmit
   output logic [NP-1:0]         O_DS_TX_VALID,
   output logic [NP*DW-1:0]      O_DS_TX_DATA,
   output logic [NP-1:0]         O_DS_TX_SKIP,
   input  wire logic [NP-1:0]    I_DS_TX_READY
);
   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int PW = $clog2(NP);          // port index width
   localparam int QW = $clog2(QD);          // region pointer width
   localparam int HD = `HUB_HOLD_DEPTH;     // hold queue entries
   localparam int HW = $clog2(HD);          // hold pointer width
   localparam int NL = NP + 1;              // lanes, last one upstream

   // ------------------------------------------------------------
   // decoding helpers
   // ------------------------------------------------------------
   // destination port field of a downstream-bound header
   function automatic logic [PW-1:0] dest_of(input logic [DW-1:0] w);
      return w[`HUB_DEST_LSB +: PW];
   endfunction : dest_of

   // round robin pick after last winner, msb flags a hit
   function automatic logic [PW:0] rr_pick(input logic [NP-1:0] req,
                                           input logic [PW-1:0] last);
      logic [PW:0]   r;
      logic [PW-1:0] idx;
      r = '0;
      for (int i = NP; i >= 1; i--) begin
         idx = last + PW'(i);
         if (req[idx]) begin
            r = {1'b1, idx};
         end
      end
      return r;
   endfunction : rr_pick

   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic              lrst_meta_reg;        // link reset, first stage
   logic              lrst_n_reg;           // link reset, synchronised
   logic              cdc_v;                // link fifo head valid
   logic [DW-1:0]     cdc_d;                // link fifo head word
   logic              cdc_pop;              // link fifo head consumed
   logic [QW:0]       cnt_reg  [2][NP];     // region fill, 0 down, 1 up
   logic [QW-1:0]     wp_reg   [2][NP];     // region write pointers
   logic [QW-1:0]     rp_reg   [2][NP];     // region read pointers
   logic [NP-1:0]     room     [2];         // region not full
   logic [NP-1:0]     wr_hit   [2];         // region written this cycle
   logic [NP-1:0]     rd_hit   [2];         // region read this cycle
   logic [NP-1:0]     rd_req   [2];         // region wants a read
   logic              wr_en    [2];         // pool write strobe
   logic [PW-1:0]     wr_p     [2];         // pool write region
   logic [DW-1:0]     wr_d     [2];         // pool write data
   logic [PW:0]       rd_pick  [2];         // pool read winner
   logic [PW:0]       rx_grant;             // downstream receive winner
   logic              rd_v_reg [2];         // read issued last cycle
   logic [PW-1:0]     rd_p_reg [2];         // region of that read
   logic [PW-1:0]     rlast_reg[2];         // last read winner
   logic [PW-1:0]     wlast_reg;            // last receive winner
   logic [DW-1:0]     rdata    [2];         // pool read data
   logic [DW-1:0]     hold_d_reg [HD];      // parked headers
   logic [HW-1:0]     hold_h_reg;           // hold head
   logic [HW-1:0]     hold_t_reg;           // hold tail
   logic [HW:0]       hold_n_reg;           // hold fill
   logic [HW:0]       held_reg [NP];        // parked headers per port
   logic [PW-1:0]     hh_p;                 // hold head destination
   logic [PW-1:0]     ch_p;                 // link head destination
   logic              hold_go;              // hold head moves to its region
   logic              cdc_direct;           // link head goes straight in
   logic              cdc_park;             // link head is parked
   logic [NL-1:0]     stage_v_reg;          // lane staging valid
   logic [DW-1:0]     stage_d_reg [NL];     // lane staging word
   logic [NL-1:0]     take;                 // lane took its staged word
   logic [NL-1:0]     tx_rdy;               // lane link ready
   logic [NL-1:0]     tx_v;                 // lane presents a word
   logic [NL-1:0]     tx_s;                 // lane in skip slot

   // ------------------------------------------------------------
   // link clock domain
   // ------------------------------------------------------------
   // reset into the link domain, first stage feeds only the second
   always_ff @(posedge I_LCLK) begin
      lrst_meta_reg <= I_RESET_N;
      lrst_n_reg    <= lrst_meta_reg;
   end

   // received words cross onto the core clock here; only O_US_RX_READY
   // leaves the hub on the recovered clock
   hub_cdc_fifo #(
      .DW    (DW),
      .DEPTH (`HUB_FIFO_DEPTH)
   ) u_us_fifo (
      .i_wclk   (I_LCLK),
      .i_wrst_n (lrst_n_reg),
      .i_wvalid (I_US_RX_VALID),
      .i_wdata  (I_US_RX_DATA),
      .o_wready (O_US_RX_READY),
      .i_rclk   (I_MCLK),
      .i_rrst_n (I_RESET_N),
      .o_rvalid (cdc_v),
      .o_rdata  (cdc_d),
      .i_rready (cdc_pop)
   );

   // ------------------------------------------------------------
   // downstream-bound routing
   // ------------------------------------------------------------
   // a parked header for a port goes before any newer one for it;
   // a head for a port with room and nothing parked is never parked,
   // but waits in any cycle in which the hold head moves to its region
   always_comb begin
      hh_p       = dest_of(hold_d_reg[hold_h_reg]);
      ch_p       = dest_of(cdc_d);
      hold_go    = (hold_n_reg != '0) && room[0][hh_p];
      cdc_direct = cdc_v && !hold_go && room[0][ch_p]
                   && (held_reg[ch_p] == '0);
      cdc_park   = cdc_v && !(room[0][ch_p] && held_reg[ch_p] == '0)
                   && (hold_n_reg != (HW+1)'(HD));
      cdc_pop    = cdc_direct || cdc_park;
      wr_en[0]   = hold_go || cdc_direct;
      wr_p[0]    = hold_go ? hh_p : ch_p;
      wr_d[0]    = hold_go ? hold_d_reg[hold_h_reg] : cdc_d;
   end

   // hold queue, in arrival order
   always_ff @(posedge I_MCLK) begin
      if (!I_RESET_N) begin
         hold_h_reg <= '0;
         hold_t_reg <= '0;
         hold_n_reg <= '0;
      end else begin
         if (hold_go) begin
            hold_h_reg <= hold_h_reg + HW'(1);
         end
         if (cdc_park) begin
            hold_d_reg[hold_t_reg] <= cdc_d;
            hold_t_reg <= hold_t_reg + HW'(1);
         end
         if (cdc_park && !hold_go) begin
            hold_n_reg <= hold_n_reg + (HW+1)'(1);
         end else if (!cdc_park && hold_go) begin
            hold_n_reg <= hold_n_reg - (HW+1)'(1);
         end
      end
   end

   // parked count per port, keeps later headers behind parked ones
   always_ff @(posedge I_MCLK) begin
      for (int p = 0; p < NP; p++) begin
         if (!I_RESET_N) begin
            held_reg[p] <= '0;
         end else if (cdc_park && ch_p == PW'(p)
                      && !(hold_go && hh_p == PW'(p))) begin
            held_reg[p] <= held_reg[p] + (HW+1)'(1);
         end else if (hold_go && hh_p == PW'(p)
                      && !(cdc_park && ch_p == PW'(p))) begin
            held_reg[p] <= held_reg[p] - (HW+1)'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // upstream-bound receive from downstream ports
   // ------------------------------------------------------------
   // one port written per cycle; ready only for the winner with room
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         rd_req[0][p] = (cnt_reg[0][p] != '0) && !stage_v_reg[p]
                        && !(rd_v_reg[0] && rd_p_reg[0] == PW'(p));
         rd_req[1][p] = (cnt_reg[1][p] != '0) && !stage_v_reg[NP]
                        && !rd_v_reg[1];
      end
      rx_grant      = rr_pick(I_DS_RX_VALID & room[1], wlast_reg);
      wr_en[1]      = rx_grant[PW];
      wr_p[1]       = rx_grant[PW-1:0];
      wr_d[1]       = I_DS_RX_DATA[rx_grant[PW-1:0]*DW +: DW];
      rd_pick[0]    = rr_pick(rd_req[0], rlast_reg[0]);
      rd_pick[1]    = rr_pick(rd_req[1], rlast_reg[1]);
      O_DS_RX_READY = '0;
      if (rx_grant[PW]) begin
         O_DS_RX_READY[rx_grant[PW-1:0]] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // region bookkeeping, both directions
   // ------------------------------------------------------------
   // each port owns a region of the pool with its own pointers, so
   // ports drain independently and out of arrival order between them
   always_comb begin
      for (int d = 0; d < 2; d++) begin
         for (int p = 0; p < NP; p++) begin
            room[d][p]   = cnt_reg[d][p] != (QW+1)'(QD);
            wr_hit[d][p] = wr_en[d] && wr_p[d] == PW'(p);
            rd_hit[d][p] = rd_pick[d][PW] && rd_pick[d][PW-1:0] == PW'(p);
         end
      end
   end

   // pointers and fill per region, each region is first in first out
   always_ff @(posedge I_MCLK) begin
      for (int d = 0; d < 2; d++) begin
         for (int p = 0; p < NP; p++) begin
            if (!I_RESET_N) begin
               cnt_reg[d][p] <= '0;
               wp_reg[d][p]  <= '0;
               rp_reg[d][p]  <= '0;
            end else begin
               if (wr_hit[d][p]) begin
                  wp_reg[d][p] <= wp_reg[d][p] + QW'(1);
               end
               if (rd_hit[d][p]) begin
                  rp_reg[d][p] <= rp_reg[d][p] + QW'(1);
               end
               if (wr_hit[d][p] && !rd_hit[d][p]) begin
                  cnt_reg[d][p] <= cnt_reg[d][p] + (QW+1)'(1);
               end else if (!wr_hit[d][p] && rd_hit[d][p]) begin
                  cnt_reg[d][p] <= cnt_reg[d][p] - (QW+1)'(1);
               end
            end
         end
      end
   end

   // arbiter history and read tracking
   always_ff @(posedge I_MCLK) begin
      if (!I_RESET_N) begin
         wlast_reg <= '0;
         for (int d = 0; d < 2; d++) begin
            rd_v_reg[d]  <= 1'b0;
            rd_p_reg[d]  <= '0;
            rlast_reg[d] <= '0;
         end
      end else begin
         if (rx_grant[PW]) begin
            wlast_reg <= rx_grant[PW-1:0];
         end
         for (int d = 0; d < 2; d++) begin
            rd_v_reg[d] <= rd_pick[d][PW];
            rd_p_reg[d] <= rd_pick[d][PW-1:0];
            if (rd_pick[d][PW]) begin
               rlast_reg[d] <= rd_pick[d][PW-1:0];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // buffer pools, 0 downstream-bound, 1 upstream-bound
   // ------------------------------------------------------------
   // QD words per port: default gives 512 bytes per port and 2048
   // per pool, above 1080 bytes and above 18 slots per hub
   for (genvar d = 0; d < 2; d++) begin : g_pool
      hub_buf_mem #(
         .DW (DW),
         .AW (PW + QW)
      ) u_mem (
         .i_clk   (I_MCLK),
         .i_rst_n (I_RESET_N),
         .i_we    (wr_en[d]),
         .i_waddr ({wr_p[d], wp_reg[d][wr_p[d]]}),
         .i_wdata (wr_d[d]),
         .i_re    (rd_pick[d][PW]),
         .i_raddr ({rd_pick[d][PW-1:0], rp_reg[d][rd_pick[d][PW-1:0]]}),
         .o_rdata (rdata[d])
      );
   end

   // ------------------------------------------------------------
   // lane staging
   // ------------------------------------------------------------
   // read data lands one cycle after the read; a lane only asks when
   // its stage is empty, so a load never meets a take
   always_ff @(posedge I_MCLK) begin
      if (!I_RESET_N) begin
         stage_v_reg <= '0;
      end else begin
         for (int k = 0; k < NL; k++) begin
            if (take[k]) begin
               stage_v_reg[k] <= 1'b0;
            end
         end
         if (rd_v_reg[0]) begin
            stage_v_reg[rd_p_reg[0]] <= 1'b1;
            stage_d_reg[rd_p_reg[0]] <= rdata[0];
         end
         if (rd_v_reg[1]) begin
            stage_v_reg[NP] <= 1'b1;
            stage_d_reg[NP] <= rdata[1];
         end
      end
   end

   // ------------------------------------------------------------
   // transmit lanes on the local clock
   // ------------------------------------------------------------
   assign tx_rdy        = {I_US_TX_READY, I_DS_TX_READY};
   assign O_DS_TX_VALID = tx_v[NP-1:0];
   assign O_DS_TX_SKIP  = tx_s[NP-1:0];
   assign O_US_TX_VALID = tx_v[NP];
   assign O_US_TX_SKIP  = tx_s[NP];

   for (genvar k = 0; k < NL; k++) begin : g_lane
      hub_sf_pkg::lane_state_e st_reg;      // lane state
      logic [DW-1:0]           out_reg;     // word on the link
      logic [7:0]              skc_reg;     // words since last skip
      logic [3:0]              gap_reg;     // spacing countdown

      assign take[k] = (st_reg == hub_sf_pkg::LANE_IDLE)
                       && (skc_reg != `HUB_SKP_WORDS) && stage_v_reg[k];
      assign tx_v[k] = st_reg == hub_sf_pkg::LANE_BUSY;
      assign tx_s[k] = st_reg == hub_sf_pkg::LANE_SKIP;

      if (k < NP) begin : g_ds
         assign O_DS_TX_DATA[k*DW +: DW] = out_reg;
      end else begin : g_us
         assign O_US_TX_DATA = out_reg;
      end

      // a skip slot only falls between words, never inside one
      always_ff @(posedge I_MCLK) begin
         if (!I_RESET_N) begin
            st_reg  <= hub_sf_pkg::LANE_IDLE;
            out_reg <= '0;
            skc_reg <= '0;
            gap_reg <= '0;
         end else begin
            unique case (st_reg)
               hub_sf_pkg::LANE_IDLE: begin
                  if (skc_reg == `HUB_SKP_WORDS) begin
                     st_reg <= hub_sf_pkg::LANE_SKIP;
                  end else if (stage_v_reg[k]) begin
                     out_reg <= stage_d_reg[k];
                     st_reg  <= hub_sf_pkg::LANE_BUSY;
                  end
               end
               hub_sf_pkg::LANE_BUSY: begin
                  if (tx_rdy[k]) begin
                     skc_reg <= skc_reg + 8'h01;
                     gap_reg <= `HUB_HDR_GAP;
                     st_reg  <= hub_sf_pkg::LANE_GAP;
                  end
               end
               hub_sf_pkg::LANE_GAP: begin
                  gap_reg <= gap_reg - 4'h1;
                  if (gap_reg == 4'h1) begin
                     st_reg <= hub_sf_pkg::LANE_IDLE;
                  end
               end
               hub_sf_pkg::LANE_SKIP: begin
                  skc_reg <= '0;
                  st_reg  <= hub_sf_pkg::LANE_IDLE;
               end
            endcase
         end
      end
   end
endmodule : hub_sf_router

/* hdl/hub_sf_regs.svh */
// constants of the hub store-and-forward router
`ifndef HUB_SF_REGS_SVH
`define HUB_SF_REGS_SVH
// ---------------------------------------------------------------
// buffer sizing
// ---------------------------------------------------------------
`define HUB_FIFO_DEPTH     16
`define HUB_REGION_DEPTH   128
`define HUB_HOLD_DEPTH     4
`define HUB_GEN1_HDR_MIN   8
`define HUB_DATA_BYTES_MIN 1080
`define HUB_PLUS_US_SLOTS  16
`define HUB_PLUS_DS_SLOTS  18
// ---------------------------------------------------------------
// header word fields and transmit timing
// ---------------------------------------------------------------
`define HUB_DEST_LSB       0
`define HUB_SKP_WORDS      8'h40
`define HUB_HDR_GAP        4'h2
`endif

/* hdl/hub_sf_pkg.sv */
// types shared by the hub store-and-forward router
package hub_sf_pkg;
   // ------------------------------------------------------------
   // transmit lane states, one-hot
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      LANE_IDLE = 4'h1,   // waiting for a staged word
      LANE_BUSY = 4'h2,   // word presented to the link
      LANE_GAP  = 4'h4,   // spacing after a word
      LANE_SKIP = 4'h8    // skip set slot
   } lane_state_e;
endpackage : hub_sf_pkg

/* hdl/hub_cdc_fifo.sv */
// dual-clock word fifo with gray-coded pointers
`timescale 1ns/10ps
module hub_cdc_fifo #(
   parameter int DW    = 32,
   parameter int DEPTH = 16
) (
   // write side, link clock
   input  wire logic          i_wclk,
   input  wire logic          i_wrst_n,
   input  wire logic          i_wvalid,
   input  wire logic [DW-1:0] i_wdata,
   output logic               o_wready,
   // read side, core clock
   input  wire logic          i_rclk,
   input  wire logic          i_rrst_n,
   output logic               o_rvalid,
   output logic [DW-1:0]      o_rdata,
   input  wire logic          i_rready
);
   localparam int AW = $clog2(DEPTH);
   logic [DW-1:0] mem_reg [DEPTH];          // storage, written on link clock only
   logic [AW:0]   wbin_reg, wgry_reg;       // write pointer, binary and gray
   logic [AW:0]   rbin_reg, rgry_reg;       // read pointer, binary and gray
   logic [AW:0]   rgry_m_reg, rgry_s_reg;   // read pointer into write domain
   logic [AW:0]   wgry_m_reg, wgry_s_reg;   // write pointer into read domain
   logic [AW:0]   wbin_next, rbin_next;     // advanced pointers

   assign wbin_next = wbin_reg + (AW+1)'(1);
   assign rbin_next = rbin_reg + (AW+1)'(1);
   // full when gray pointers differ only in the two top bits
   assign o_wready  = wgry_reg != {~rgry_s_reg[AW:AW-1], rgry_s_reg[AW-2:0]};
   assign o_rvalid  = rgry_reg != wgry_s_reg;
   assign o_rdata   = mem_reg[rbin_reg[AW-1:0]];

   // write side, pointer only moves on an accepted word
   always_ff @(posedge i_wclk) begin
      if (!i_wrst_n) begin
         wbin_reg   <= '0;
         wgry_reg   <= '0;
         rgry_m_reg <= '0;
         rgry_s_reg <= '0;
      end else begin
         rgry_m_reg <= rgry_reg;
         rgry_s_reg <= rgry_m_reg;
         if (i_wvalid && o_wready) begin
            mem_reg[wbin_reg[AW-1:0]] <= i_wdata;
            wbin_reg <= wbin_next;
            wgry_reg <= wbin_next ^ (wbin_next >> 1);
         end
      end
   end

   // read side, empty is seen late so it is always safe
   always_ff @(posedge i_rclk) begin
      if (!i_rrst_n) begin
         rbin_reg   <= '0;
         rgry_reg   <= '0;
         wgry_m_reg <= '0;
         wgry_s_reg <= '0;
      end else begin
         wgry_m_reg <= wgry_reg;
         wgry_s_reg <= wgry_m_reg;
         if (o_rvalid && i_rready) begin
            rbin_reg <= rbin_next;
            rgry_reg <= rbin_next ^ (rbin_next >> 1);
         end
      end
   end
endmodule : hub_cdc_fifo

/* hdl/hub_buf_mem.sv */
// simple dual-port buffer memory with registered read data
`timescale 1ns/10ps
module hub_buf_mem #(
   parameter int DW = 32,
   parameter int AW = 9
) (
   // clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_rst_n,
   // write port
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [DW-1:0] i_wdata,
   // read port
   input  wire logic          i_re,
   input  wire logic [AW-1:0] i_raddr,
   output logic [DW-1:0]      o_rdata
);
   logic [DW-1:0] mem_reg [2**AW];          // array, never reset

   // write
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem_reg[i_waddr] <= i_wdata;
      end
   end

   // read, one cycle latency
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_rdata <= '0;
      end else if (i_re) begin
         o_rdata <= mem_reg[i_raddr];
      end
   end
endmodule : hub_buf_mem

/* sim/hub_link_partner.sv */
// far-side link partners that pace the downstream transmit ports
`timescale 1ns/10ps
module hub_link_partner #(parameter int NP = 4) (
   // pacing controls from the bench
   input  wire logic          i_clk,
   input  wire logic [NP-1:0] i_stall,
   input  wire logic          i_slow,
   // ready toward the router
   output logic [NP-1:0]      o_ready
);
   logic [1:0] pace_reg = 2'h0;  // free-running pace count
   // a slow partner is ready one cycle in four; a stalled port stands for a link not in U0
   always_ff @(posedge i_clk) begin
      pace_reg <= pace_reg + 2'h1;
   end
   assign o_ready = ~i_stall & {NP{!i_slow || pace_reg == 2'h0}};
endmodule : hub_link_partner

/* sim/hub_sf_router_monitor.sv */
// checker for the router transmit and receive handshakes
`timescale 1ns/10ps
module hub_sf_router_monitor #(parameter int DW = 32, parameter int NP = 4) (
   input wire logic          I_MCLK,
   input wire logic          I_RESET_N,
   input wire logic          O_US_TX_VALID,
   input wire logic [DW-1:0] O_US_TX_DATA,
   input wire logic          O_US_TX_SKIP,
   input wire logic          I_US_TX_READY,
   input wire logic [NP-1:0] I_DS_RX_VALID,
   input wire logic [NP-1:0] O_DS_RX_READY,
   input wire logic [NP-1:0] O_DS_TX_VALID,
   input wire logic [NP-1:0] I_DS_TX_READY
);
   // ---------------------------------------------------------------
   // one core domain, quiet while reset is low
   // ---------------------------------------------------------------
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RESET_N);
   sequence s_up_take; O_US_TX_VALID && I_US_TX_READY; endsequence
   sequence s_dn_take; O_DS_TX_VALID[0] && I_DS_TX_READY[0]; endsequence
   property p_up_hold;
      O_US_TX_VALID && !I_US_TX_READY |=> O_US_TX_VALID && $stable(O_US_TX_DATA); endproperty
   property p_up_gap; s_up_take |=> (!O_US_TX_VALID) [*2]; endproperty
   property p_skip_one; O_US_TX_SKIP |=> !O_US_TX_SKIP; endproperty
   property p_skip_idle; O_US_TX_SKIP |-> !O_US_TX_VALID; endproperty
   property p_dn_hold; O_DS_TX_VALID[0] && !I_DS_TX_READY[0] |=> O_DS_TX_VALID[0]; endproperty
   property p_dn_gap; s_dn_take |=> (!O_DS_TX_VALID[0]) [*2]; endproperty
   property p_rx_grant; (O_DS_RX_READY & ~I_DS_RX_VALID) == '0; endproperty
   property p_rx_one; $onehot0(O_DS_RX_READY); endproperty
   a_up_hold: assert property (p_up_hold) else $error("up hold");
   a_up_gap: assert property (p_up_gap) else $error("up gap");
   a_skip_one: assert property (p_skip_one) else $error("skip width");
   a_skip_idle: assert property (p_skip_idle) else $error("skip clash");
   a_dn_hold: assert property (p_dn_hold) else $error("dn hold");
   a_dn_gap: assert property (p_dn_gap) else $error("dn gap");
   a_rx_grant: assert property (p_rx_grant) else $error("rx grant");
   a_rx_one: assert property (p_rx_one) else $error("rx one");
endmodule : hub_sf_router_monitor
bind hub_sf_router hub_sf_router_monitor #(.DW(DW), .NP(NP)) u_mon (
   .I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .O_US_TX_VALID(O_US_TX_VALID),
   .O_US_TX_DATA(O_US_TX_DATA), .O_US_TX_SKIP(O_US_TX_SKIP), .I_US_TX_READY(I_US_TX_READY),
   .I_DS_RX_VALID(I_DS_RX_VALID), .O_DS_RX_READY(O_DS_RX_READY),
   .O_DS_TX_VALID(O_DS_TX_VALID), .I_DS_TX_READY(I_DS_TX_READY));

/* sim/hub_sf_router_test.sv */
// bench for the hub store-and-forward router
`timescale 1ns/10ps
module hub_sf_router_test;
   logic I_MCLK = '0, I_LCLK = '0, I_RESET_N = '0, I_US_RX_VALID = '0, I_US_TX_READY = '0;
   logic O_US_RX_READY, O_US_TX_VALID, O_US_TX_SKIP, slow = '0;
   logic [31:0] I_US_RX_DATA = '0, O_US_TX_DATA, exu[4][$], exd[4][$], got[4][$], up[$];
   logic [3:0] I_DS_RX_VALID = '0, O_DS_RX_READY, O_DS_TX_VALID, O_DS_TX_SKIP, I_DS_TX_READY;
   logic [3:0] stall = '0;
   logic [127:0] I_DS_RX_DATA = '0, O_DS_TX_DATA;
   int fail_count = 0, checked = 0, skips = 0, n;
   int rows[4][2] = '{'{0, 66}, '{1, 3}, '{2, 5}, '{3, 4}};  // port, words sent there
   always #10 I_MCLK = ~I_MCLK;
   initial begin
      #1.7;
      forever #3 I_LCLK = ~I_LCLK;
   end
   hub_sf_router #(.DW(32), .NP(4), .QD(16)) dut (.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N),
      .I_LCLK(I_LCLK), .I_US_RX_VALID(I_US_RX_VALID), .I_US_RX_DATA(I_US_RX_DATA),
      .O_US_RX_READY(O_US_RX_READY), .O_US_TX_VALID(O_US_TX_VALID), .O_US_TX_DATA(O_US_TX_DATA),
      .O_US_TX_SKIP(O_US_TX_SKIP), .I_US_TX_READY(I_US_TX_READY), .I_DS_RX_VALID(I_DS_RX_VALID),
      .I_DS_RX_DATA(I_DS_RX_DATA), .O_DS_RX_READY(O_DS_RX_READY), .O_DS_TX_VALID(O_DS_TX_VALID),
      .O_DS_TX_DATA(O_DS_TX_DATA), .O_DS_TX_SKIP(O_DS_TX_SKIP), .I_DS_TX_READY(I_DS_TX_READY));
   hub_link_partner #(.NP(4)) u_far (.i_clk(I_MCLK), .i_stall(stall), .i_slow(slow),
      .o_ready(I_DS_TX_READY));
   // collect every word that leaves the router
   always @(posedge I_MCLK) begin
      for (int p = 0; p < 4; p++)
         if (O_DS_TX_VALID[p] && I_DS_TX_READY[p]) got[p].push_back(O_DS_TX_DATA[p*32+:32]);
      if (O_US_TX_VALID && I_US_TX_READY) up.push_back(O_US_TX_DATA);
      if (O_US_TX_SKIP || O_DS_TX_SKIP[0]) skips++;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic print_verdict;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   task automatic give_up;
      fail_count++;
      print_verdict();
   endtask : give_up
   // link side: hold the word until ready is seen at a link edge
   task automatic us_send(input int p, input int i);
      n = 0;
      @(negedge I_LCLK);
      I_US_RX_VALID = 1'b1;
      I_US_RX_DATA = {16'(i), 14'h0, 2'(p)};
      exd[p].push_back(I_US_RX_DATA);
      do @(posedge I_LCLK); while (!O_US_RX_READY && ++n < 500);
      if (n >= 500) give_up();
      @(negedge I_LCLK);
      I_US_RX_VALID = 1'b0;
      I_US_RX_DATA = ~I_US_RX_DATA;
   endtask : us_send
   task automatic ds_send(input int p, input int i);
      n = 0;
      @(negedge I_MCLK);
      I_DS_RX_VALID[p] = 1'b1;
      I_DS_RX_DATA[p*32+:32] = {16'(i), 14'h0, 2'(p)};
      exu[p].push_back(I_DS_RX_DATA[p*32+:32]);
      do @(posedge I_MCLK); while (!O_DS_RX_READY[p] && ++n < 500);
      if (n >= 500) give_up();
      @(negedge I_MCLK);
      I_DS_RX_VALID[p] = 1'b0;
      I_DS_RX_DATA[p*32+:32] = ~I_DS_RX_DATA[p*32+:32];
   endtask : ds_send
   // port 4 stands for the upstream lane
   task automatic drain(input int p, input int k);
      for (n = 0; n < 4000 && (p < 4 ? got[p].size() : up.size()) < k; n++) @(negedge I_MCLK);
      if (n >= 4000) give_up();
   endtask : drain
   task automatic cmp_dn;
      for (int p = 0; p < 4; p++) begin
         chk("dn count", 32'(exd[p].size()), 32'(got[p].size()));
         for (int i = 0; i < got[p].size(); i++) chk("dn word", exd[p][i], got[p][i]);
         got[p].delete();
         exd[p].delete();
      end
   endtask : cmp_dn
   initial begin
      repeat (8) @(negedge I_MCLK);
      chk("tx valid", '0, {27'h0, O_US_TX_VALID, O_DS_TX_VALID});
      I_RESET_N = 1'b1;
      repeat (2) @(negedge I_MCLK);
      I_US_TX_READY = 1'b1;
      slow = 1'b1;
      foreach (rows[r]) for (int i = 0; i < rows[r][1]; i++) us_send(rows[r][0], i);
      foreach (rows[r]) drain(rows[r][0], rows[r][1]);
      cmp_dn();
      slow = 1'b0;
      stall = 4'h4;
      for (int i = 0; i < 8; i++) us_send(2, i);
      us_send(1, 9);
      drain(1, 1);
      chk("parked", 32'h0, 32'(got[2].size() + !O_DS_TX_VALID[2]));
      stall = 4'h0;
      drain(2, 8);
      cmp_dn();
      I_US_TX_READY = 1'b0;
      for (int p = 0; p < 4; p++) for (int i = 0; i < 16; i++) ds_send(p, i);
      I_US_TX_READY = 1'b1;
      drain(4, 64);
      foreach (up[i]) chk("up word", exu[up[i][1:0]].pop_front(), up[i]);
      for (n = 0; n < 50 && skips < 2; n++) @(negedge I_MCLK);
      chk("skips", 32'h1, 32'(skips >= 2));
      print_verdict();
   end
endmodule : hub_sf_router_test
